// >>> scp_consts.svh
// Offsets, field positions and timing counts for the serial control port and timers
// What this block does
// - Host loads a byte; port exchanges it with the peripheral MSB first.
// - Reading the shift register mid-exchange returns zero.
// - After an exchange the shift register holds the received byte.
// - Master start issues eight clock pulses, then start bit clears itself.
// - In slave mode start bit and first select bit do nothing.
// - First select bit drives the active-low select pin directly.
// - Second select bit drives channel 1 carrier pin only when that channel enabled.
// - Divider field picks master clock divided by 2, 4, 8 or 16.
// - The selected divider tap also clocks both timers.
// - Invert clear: drive on rising, sample on falling, idle low.
// - Invert set: drive on falling, sample on rising, idle high.
// - Slave/master bit zero means master, one means slave.
// - Completion sets interrupt status; host clears it after reading it set.
// - Port works only while channel 0 port enable is set.
// - Reset clears the whole port control and shift register.
// - Port-complete enable gates the completion interrupt in both modes.
// - Each timer counts down and interrupts on wrap to all ones.
// - Timers decrement once per 1024 serial clock periods.
// - Timer counts may be read or written at any time.
// - A decrement coinciding with an access to that timer is dropped.
// - Timer enable gates counting and interrupt; reset keeps the count.
// - Watchdog adds divide-by-16 and pulls reset low 16 clocks on underflow.
// - Timer status sets on underflow; host clears it after reading it set.
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH
`define ADDR_PORT 8'h10
`define ADDR_TMR0 8'h12
`define ADDR_TMR1 8'h14
`define BIT_IRQ 15
`define BIT_SM 14
`define BIT_CI 13
`define BIT_BRS_HI 11
`define BIT_BRS_LO 10
`define BIT_EN1 9
`define BIT_EN0 8
`define BIT_TX 12
`define BIT_TIMER_IRQ_STATUS 10
`define BIT_WDE 9
`define BIT_TEN 8
`define PORT_RESET 16'h0000
`define PRESCALE 10'h3ff
`define WD_PRESCALE 4'hf
`define WD_RESET_CYCLES 5'h10
`define BITS_PER_XFER 4'h8
`endif

// >>> scp_pkg.sv
// Types for the serial control port and timers
package scp_pkg;
    typedef enum logic [1:0] {idle_s, run_s, done_s} port_state_t;
endpackage : scp_pkg

// >>> serial_control_port_and_timers.sv
// Serial control port with two protocol timers behind a host register port
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.svh"
module serial_control_port_and_timers (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Host register port
    input wire logic [7:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    // Channel enables from serial interface control registers
    input wire logic port_enable_bit,
    input wire logic ch1_port_enable_bit,
    // Peripheral link
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic sclk_in,
    output logic mosi,
    input wire logic miso,
    output logic periph_select_pin_b,
    output logic carrier_detect_pin_b,
    // Interrupts and watchdog reset pin
    input wire logic port_complete_irq_enable,
    output logic port_irq,
    output logic timer_irq,
    output logic reset_pin_out,
    output logic reset_pin_oe
);
    // Register fields
    logic irq_r, sm_r, ci_r, en1_r, en0_r, tx_r;
    logic [1:0] divider_select_r;
    logic [7:0] shift_r;
    logic irq_seen_r;
    logic [7:0] timer_count_r [2];
    logic [1:0] ten_r, timer_irq_status_r, timer_irq_status_seen_r;
    logic wde_r;
    scp_pkg::port_state_t state_r;
    logic [3:0] bits_r;
    logic [3:0] edges_r;
    logic [7:0] out_r;
    logic mosi_bit_r;
    logic [4:0] cap_pipe_r;
    logic capture;
    logic [3:0] div_r;
    logic tap_r, tap_d_r;
    logic tap_tick;
    logic sclk_r;
    logic [2:0] sclk_sync_r, miso_sync_r;
    logic miso_s_r;
    logic sclk_s_r, sclk_s_d_r;
    logic done_p;
    logic [9:0] pre_r;
    logic [3:0] wd_pre_r;
    logic [4:0] wd_cnt_r;
    logic acc_port, acc_t0, acc_t1;

    assign acc_port = (rd | wr) && addr == `ADDR_PORT;
    assign acc_t0 = (rd | wr) && addr == `ADDR_TMR0;
    assign acc_t1 = (rd | wr) && addr == `ADDR_TMR1;

    // Divider chain; tap toggles at selected rate
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            div_r <= 4'h0;
        end else if (clk_en) begin
            div_r <= div_r + 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tap_r <= 1'b0;
            tap_d_r <= 1'b0;
        end else if (clk_en) begin
            tap_r <= div_r[divider_select_r];
            tap_d_r <= tap_r;
        end
    end

    // Half-period tick of the serial clock
    assign tap_tick = tap_r != tap_d_r;

    // Pin synchronisers: three stages, change taken when stages two and three agree
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sclk_sync_r <= 3'h0;
            miso_sync_r <= 3'h0;
            sclk_s_r <= 1'b0;
            miso_s_r <= 1'b0;
            sclk_s_d_r <= 1'b0;
        end else if (clk_en) begin
            sclk_sync_r <= {sclk_sync_r[1:0], sclk_in};
            miso_sync_r <= {miso_sync_r[1:0], miso};
            if (sclk_sync_r[1] == sclk_sync_r[2]) begin
                sclk_s_r <= sclk_sync_r[2];
            end
            if (miso_sync_r[1] == miso_sync_r[2]) begin
                miso_s_r <= miso_sync_r[2];
            end
            sclk_s_d_r <= sclk_s_r;
        end
    end

    // Port exchange engine
    logic m_lead, m_trail, s_rise, s_fall, s_lead, s_trail, lead, trail;
    logic sclk_nxt;
    assign sclk_nxt = ~sclk_r;
    // Leading edge moves away from idle level, trailing edge returns
    assign m_lead = state_r == scp_pkg::run_s && !sm_r && tap_tick && sclk_r == ci_r &&
                    edges_r != `BITS_PER_XFER;
    assign m_trail = state_r == scp_pkg::run_s && !sm_r && tap_tick && sclk_r != ci_r;
    assign s_rise = sclk_s_r && !sclk_s_d_r;
    assign s_fall = !sclk_s_r && sclk_s_d_r;
    // With invert clear sample falling; with invert set sample rising
    assign s_lead = ci_r ? s_fall : s_rise;
    assign s_trail = ci_r ? s_rise : s_fall;
    assign lead = sm_r ? s_lead : m_lead;
    assign trail = sm_r ? s_trail : m_trail;
    assign done_p = state_r == scp_pkg::done_s;
    // Master samples five cycles after its trailing edge to cover pin sync latency
    assign capture = sm_r ? trail : cap_pipe_r[4];

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cap_pipe_r <= 5'h00;
        end else if (clk_en) begin
            cap_pipe_r <= {cap_pipe_r[3:0], m_trail};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_r <= scp_pkg::idle_s;
            bits_r <= 4'h0;
            sclk_r <= 1'b0;
            shift_r <= 8'h00;
            edges_r <= 4'h0;
            out_r <= 8'h00;
            mosi_bit_r <= 1'b0;
        end else if (clk_en) begin
            unique case (state_r)
                scp_pkg::idle_s: begin
                    sclk_r <= ci_r;
                    bits_r <= 4'h0;
                    edges_r <= 4'h0;
                    if (wr && addr == `ADDR_PORT) begin
                        shift_r <= wdata[7:0];
                    end
                    mosi_bit_r <= shift_r[7];
                    out_r <= shift_r;
                    // Master starts on transmit bit; slave on first external leading edge
                    if (port_enable_bit && !sm_r && tx_r && tap_tick) begin
                        state_r <= scp_pkg::run_s;
                    end else if (port_enable_bit && sm_r && s_lead) begin
                        state_r <= scp_pkg::run_s;
                        out_r <= {shift_r[6:0], 1'b0};
                    end
                end
                scp_pkg::run_s: begin
                    if (!port_enable_bit) begin
                        state_r <= scp_pkg::idle_s;
                    end else begin
                        if (m_lead || m_trail) begin
                            sclk_r <= sclk_nxt;
                        end
                        if (m_trail) begin
                            edges_r <= edges_r + 4'h1;
                        end
                        // Outgoing bit changes on leading edge
                        if (lead) begin
                            mosi_bit_r <= out_r[7];
                            out_r <= {out_r[6:0], 1'b0};
                        end
                        if (capture) begin
                            shift_r <= {shift_r[6:0], miso_s_r};
                            bits_r <= bits_r + 4'h1;
                            if (bits_r == `BITS_PER_XFER - 4'h1) begin
                                state_r <= scp_pkg::done_s;
                            end
                        end
                    end
                end
                scp_pkg::done_s: begin
                    state_r <= scp_pkg::idle_s;
                end
            endcase
        end
    end

    // Master drives clock; slave releases it
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sclk_out <= 1'b0;
            sclk_oe <= 1'b0;
            mosi <= 1'b0;
        end else if (clk_en) begin
            sclk_out <= sclk_r;
            mosi <= mosi_bit_r;
            sclk_oe <= port_enable_bit && !sm_r;
        end
    end

    // Control bits of the port register
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            {sm_r, ci_r, divider_select_r, en1_r, en0_r} <= 6'h00;
        end else if (clk_en && wr && addr == `ADDR_PORT) begin
            sm_r <= wdata[`BIT_SM];
            ci_r <= wdata[`BIT_CI];
            divider_select_r <= wdata[`BIT_BRS_HI:`BIT_BRS_LO];
            en1_r <= wdata[`BIT_EN1];
            en0_r <= wdata[`BIT_EN0];
        end
    end

    // Transmit bit clears itself when the exchange ends
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tx_r <= 1'b0;
        end else if (clk_en) begin
            if (done_p) begin
                tx_r <= 1'b0;
            end else if (wr && addr == `ADDR_PORT && state_r == scp_pkg::idle_s) begin
                tx_r <= wdata[`BIT_TX];
            end
        end
    end

    // Port interrupt status: set wins; clear only after read as one
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_r <= 1'b0;
            irq_seen_r <= 1'b0;
        end else if (clk_en) begin
            if (done_p) begin
                irq_r <= 1'b1;
            end else if (wr && addr == `ADDR_PORT && !wdata[`BIT_IRQ] && irq_seen_r) begin
                irq_r <= 1'b0;
            end else if (wr && addr == `ADDR_PORT && wdata[`BIT_IRQ]) begin
                irq_r <= 1'b1;
            end
            if (rd && addr == `ADDR_PORT && irq_r) begin
                irq_seen_r <= 1'b1;
            end else if (!irq_r) begin
                irq_seen_r <= 1'b0;
            end
        end
    end

    // Timer prescaler: 1024 serial clock periods, times 16 for the watchdog
    logic period_p, pre_p, wd_p;
    assign period_p = tap_tick && !tap_r;
    assign pre_p = period_p && pre_r == `PRESCALE;
    assign wd_p = pre_p && wd_pre_r == `WD_PRESCALE;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pre_r <= 10'h000;
            wd_pre_r <= 4'h0;
        end else if (clk_en) begin
            if (period_p) begin
                pre_r <= pre_r + 10'h001;
            end
            if (pre_p) begin
                wd_pre_r <= wd_pre_r + 4'h1;
            end
        end
    end

    // Timer counters: count kept over reset
    logic [1:0] dec_p, acc_t;
    assign acc_t = {acc_t1, acc_t0};
    assign dec_p[0] = ten_r[0] && (wde_r ? wd_p : pre_p) && !acc_t0;
    assign dec_p[1] = ten_r[1] && pre_p && !acc_t1;
    always_ff @(posedge mclk) begin
        if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                if (wr && acc_t[i]) begin
                    timer_count_r[i] <= wdata[7:0];
                end else if (dec_p[i]) begin
                    timer_count_r[i] <= timer_count_r[i] - 8'h01;
                end
            end
        end
    end

    // Timer control and status
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ten_r <= 2'h0;
            wde_r <= 1'b0;
            timer_irq_status_r <= 2'h0;
            timer_irq_status_seen_r <= 2'h0;
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                if (wr && acc_t[i]) begin
                    ten_r[i] <= wdata[`BIT_TEN];
                end
                if (dec_p[i] && timer_count_r[i] == 8'h00) begin
                    timer_irq_status_r[i] <= 1'b1;
                end else if (wr && acc_t[i] && !wdata[`BIT_TIMER_IRQ_STATUS] && timer_irq_status_seen_r[i]) begin
                    timer_irq_status_r[i] <= 1'b0;
                end else if (wr && acc_t[i] && wdata[`BIT_TIMER_IRQ_STATUS]) begin
                    timer_irq_status_r[i] <= 1'b1;
                end
                if (rd && acc_t[i] && timer_irq_status_r[i]) begin
                    timer_irq_status_seen_r[i] <= 1'b1;
                end else if (!timer_irq_status_r[i]) begin
                    timer_irq_status_seen_r[i] <= 1'b0;
                end
            end
            if (wr && acc_t0) begin
                wde_r <= wdata[`BIT_WDE];
            end
        end
    end

    // Watchdog reset drive
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wd_cnt_r <= 5'h00;
            reset_pin_out <= 1'b1;
            reset_pin_oe <= 1'b0;
        end else if (clk_en) begin
            if (wde_r && dec_p[0] && timer_count_r[0] == 8'h00) begin
                wd_cnt_r <= `WD_RESET_CYCLES;
            end else if (wd_cnt_r != 5'h00) begin
                wd_cnt_r <= wd_cnt_r - 5'h01;
            end
            reset_pin_out <= 1'b0;
            reset_pin_oe <= (wde_r && dec_p[0] && timer_count_r[0] == 8'h00) || wd_cnt_r > 5'h01;
        end
    end

    // Pins, interrupt outputs and read data
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            periph_select_pin_b <= 1'b1;
            carrier_detect_pin_b <= 1'b1;
            port_irq <= 1'b0;
            timer_irq <= 1'b0;
            rdata <= 16'h0000;
        end else if (clk_en) begin
            periph_select_pin_b <= sm_r ? 1'b1 : ~en0_r;
            carrier_detect_pin_b <= ch1_port_enable_bit ? ~en1_r : 1'b1;
            port_irq <= irq_r && port_complete_irq_enable;
            timer_irq <= |(timer_irq_status_r & ten_r);
            if (rd && acc_port) begin
                rdata <= {irq_r, sm_r, ci_r, tx_r, divider_select_r, en1_r, en0_r,
                          (state_r == scp_pkg::idle_s ? shift_r : 8'h00)};
            end else if (rd && acc_t0) begin
                rdata <= {5'h00, timer_irq_status_r[0], wde_r, ten_r[0], timer_count_r[0]};
            end else if (rd && acc_t1) begin
                rdata <= {5'h00, timer_irq_status_r[1], 1'b0, ten_r[1], timer_count_r[1]};
            end else if (rd) begin
                rdata <= 16'h0000;
            end
        end
    end
endmodule : serial_control_port_and_timers
`default_nettype wire

// >>> scp_periph_model.sv
// Behavioural peripheral that answers the serial port as a shift-register slave
`timescale 1ns/1ps
`default_nettype none
module scp_periph_model (
    // Serial link
    input wire logic sclk,
    input wire logic sel_b,
    input wire logic ci,
    input wire logic mosi,
    output logic miso,
    // Bytes exchanged
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    logic [7:0] sh = 8'h00;
    initial miso = 1'b0;
    initial rx_byte = 8'h00;
    // Fresh byte on select, stale data line scrambled on release
    always @(sel_b) begin
        sh = tx_byte;
        miso = ~miso;
    end
    always @(sclk) begin
        if (!sel_b && (sclk ^ ci)) begin
            miso = sh[7];
            sh = {sh[6:0], 1'b0};
        end else if (!sel_b) begin
            rx_byte = {rx_byte[6:0], mosi};
        end
    end
endmodule : scp_periph_model
`default_nettype wire

// >>> serial_control_port_and_timers_properties.sv
// Checker for pin and register timing of the serial port and timers
`timescale 1ns/1ps
`default_nettype none
module scp_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Host port
    input wire logic [7:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    // Enables
    input wire logic port_enable_bit,
    input wire logic ch1_port_enable_bit,
    input wire logic port_complete_irq_enable,
    // Pins and flags
    input wire logic sclk_oe,
    input wire logic periph_select_pin_b,
    input wire logic carrier_detect_pin_b,
    input wire logic port_irq,
    input wire logic timer_irq,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    property p_sel;
        logic v;
        (wr && addr == 8'h10 && !wdata[14], v = wdata[8]) |-> ##2 periph_select_pin_b == !v;
    endproperty
    a_select_follows: assert property (p_sel) else $error("select pin off");
    a_slave_quiet: assert property (
        wr && addr == 8'h10 && wdata[14] |-> ##2 !sclk_oe && periph_select_pin_b)
        else $error("slave drives pins");
    a_carrier_gated: assert property (
        !ch1_port_enable_bit [*3] |-> carrier_detect_pin_b) else $error("carrier pin driven");
    a_port_disabled: assert property (
        !port_enable_bit [*3] |-> !sclk_oe) else $error("clock driven while disabled");
    a_reset_values: assert property (disable iff (1'b0) !rst_b |=> rdata == 16'h0000 &&
        !port_irq && !timer_irq && periph_select_pin_b && carrier_detect_pin_b &&
        !sclk_oe && !reset_pin_oe) else $error("reset values off");
    a_irq_gated: assert property (
        !port_complete_irq_enable [*2] |-> !port_irq) else $error("irq not gated");
    a_wd_pulse_len: assert property ($rose(reset_pin_oe) |-> reset_pin_oe [*8] ##1
        reset_pin_oe [*8] ##1 !reset_pin_oe && !reset_pin_out) else $error("reset pulse off");
    a_rdata_holds: assert property (
        !rd && !$past(rd) |=> $stable(rdata)) else $error("read data moved");
    c_port_done: cover property ($rose(port_irq));
    c_timer_wrap: cover property ($rose(timer_irq));
    c_watchdog: cover property ($rose(reset_pin_oe));
endmodule : scp_checker
bind serial_control_port_and_timers scp_checker chk_u (.*);
`default_nettype wire

// >>> serial_control_port_and_timers_test.sv
// Self-checking bench for the serial port and timers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch at %0t: %h not %h", $time, g, e); end end
module serial_control_port_and_timers_test;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic port_enable_bit = 1'b1;
    logic ch1_port_enable_bit = 1'b0;
    logic port_complete_irq_enable = 1'b1;
    logic sclk_in = 1'b0;
    logic ext_miso = 1'b0;
    logic slave = 1'b0;
    logic ci = 1'b0;
    logic m_ci = 1'b0;
    logic [7:0] p_tx = 8'h00;
    logic [7:0] host, got, p_rx;
    logic [15:0] rdata, rv;
    logic p_miso, sclk_out, sclk_oe, mosi, periph_select_pin_b, carrier_detect_pin_b;
    logic port_irq, timer_irq, reset_pin_out, reset_pin_oe;
    wire logic miso;
    int n_errors = 0;
    int n_tests = 0;
    int n_rise = 0;
    int n0, k;
    realtime t_last, t_prev;
    assign miso = slave ? ext_miso : p_miso;
    always #10 mclk = ~mclk;
    serial_control_port_and_timers dut_u (.*);
    scp_periph_model peer_u (.sclk(sclk_out), .sel_b(periph_select_pin_b), .ci(m_ci),
        .mosi(mosi), .miso(p_miso), .tx_byte(p_tx), .rx_byte(p_rx));
    always @(posedge sclk_out) begin
        t_prev = t_last;
        t_last = $realtime;
        n_rise++;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(negedge mclk);
        addr = a;
        rd = 1'b1;
        @(negedge mclk);
        rd = 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask : rd_reg
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        rd_reg(8'h10, rv);
        `CHK(rv, 16'h0000)
        $display("reset test done");
        for (int c = 0; c < 4; c++) begin
            host = 8'hb4 + 8'(c);
            p_tx = 8'h5a ^ 8'(c);
            ci = c[0];
            wr_reg(8'h10, {2'b00, ci, 1'b0, c[1:0], 10'h000});
            m_ci = ci;
            wr_reg(8'h10, {2'b00, ci, 1'b0, c[1:0], 10'h100});
            repeat (4 << c) @(negedge mclk);
            n0 = n_rise;
            wr_reg(8'h10, {2'b00, ci, 1'b1, c[1:0], 2'b01, host});
            repeat (3) @(negedge mclk);
            rd_reg(8'h10, rv);
            `CHK(rv[7:0], 8'h00)
            for (k = 0; k < 400 && port_irq !== 1'b1; k++) @(negedge mclk);
            `CHK(port_irq, 1'b1)
            `CHK(sclk_out, ci)
            `CHK(n_rise - n0, 8)
            `CHK(int'((t_last - t_prev) / 20.0), 2 << c)
            rd_reg(8'h10, rv);
            `CHK(rv, {2'b10, ci, 1'b0, c[1:0], 2'b01, p_tx})
            `CHK(p_rx, host)
            wr_reg(8'h10, 16'h0000);
            repeat (3) @(negedge mclk);
            `CHK(port_irq, 1'b0)
        end
        $display("master exchange test done");
        port_enable_bit = 1'b0;
        n0 = n_rise;
        wr_reg(8'h10, 16'h11a5);
        repeat (100) @(negedge mclk);
        `CHK(n_rise - n0, 0)
        wr_reg(8'h10, 16'h0200);
        port_enable_bit = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK(carrier_detect_pin_b, 1'b1)
        ch1_port_enable_bit = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK(carrier_detect_pin_b, 1'b0)
        ch1_port_enable_bit = 1'b0;
        $display("enable test done");
        port_complete_irq_enable = 1'b0;
        slave = 1'b1;
        wr_reg(8'h10, 16'h41bc);
        repeat (5) @(negedge mclk);
        for (int i = 7; i >= 0; i--) begin
            sclk_in = 1'b1;
            ext_miso = 1'(8'h6e >> i);
            repeat (8) @(negedge mclk);
            sclk_in = 1'b0;
            got = {got[6:0], mosi};
            repeat (5) @(negedge mclk);
        end
        ext_miso = ~ext_miso;
        rv = 16'h0000;
        for (k = 0; k < 20 && rv[15] !== 1'b1; k++) rd_reg(8'h10, rv);
        `CHK(rv[15], 1'b1)
        `CHK(rv[7:0], 8'h6e)
        `CHK(got, 8'hbc)
        `CHK(port_irq, 1'b0)
        wr_reg(8'h10, 16'h0000);
        slave = 1'b0;
        port_complete_irq_enable = 1'b1;
        $display("slave test done");
        wr_reg(8'h12, 16'h0101);
        wr_reg(8'h14, 16'h0001);
        for (k = 0; k < 5000 && timer_irq !== 1'b1; k++) @(negedge mclk);
        `CHK(k > 2000 && k < 4200, 1'b1)
        rd_reg(8'h12, rv);
        `CHK(rv, 16'h05ff)
        rd_reg(8'h14, rv);
        `CHK(rv, 16'h0001)
        wr_reg(8'h12, 16'h0000);
        repeat (3) @(negedge mclk);
        `CHK(timer_irq, 1'b0)
        rst_b = 1'b0;
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        rd_reg(8'h14, rv);
        `CHK(rv, 16'h0001)
        $display("timer test done");
        wr_reg(8'h12, 16'h0300);
        for (k = 0; k < 36000 && reset_pin_oe !== 1'b1; k++) @(negedge mclk);
        `CHK(k > 30000, 1'b1)
        `CHK({reset_pin_oe, reset_pin_out}, 2'b10)
        repeat (20) @(negedge mclk);
        $display("watchdog test done");
        end_of_test();
    end
endmodule : serial_control_port_and_timers_test
`default_nettype wire
